// File: logic/i2csc_defs.vh
// constants and register map of the i2c slave controller
// Functional notes
// - seven-bit own address, match only it
// - slave only; direction from master's R/W bit
// - standard and fast bus speeds supported
// - control bit 7 resets whole controller
// - writing device_active one sets it immediately
// - device_active clear waits for transfer end
// - control write-only; read returns status
// - control bit 3 clears receive_finished
// - control bit 2 clears send_finished
// - status bit layout, active high
// - receive_request set on byte, cleared by read
// - transmit_request set when needed, cleared by write
// - receive_finished set when master write ends
// - send_finished set when master read ends
// - finished flags raise interrupt output
// - bus_active_flag shows transfer in progress
// - transmit byte shifted out msb first
// - data buffer: write tx, read rx
// - own address resets to 0x39
// - interrupt flag sticky until software clears
`ifndef I2CSC_DEFS_VH
`define I2CSC_DEFS_VH
`define I2CSC_OFS_OWN_ADDR   32'h5000_3804
`define I2CSC_OFS_CTRL_STAT  32'h5000_3808
`define I2CSC_OFS_DATA       32'h5000_380c
`define I2CSC_OFS_OWN_UPPER  32'h5000_3810
`define I2CSC_OFS_INT_CTRL   32'h5000_3814
`define I2CSC_BIT_SOFT_RST   7
`define I2CSC_BIT_DEV_ACT    6
`define I2CSC_BIT_BUS_ACT    4
`define I2CSC_BIT_RX_FIN     3
`define I2CSC_BIT_TX_FIN     2
`define I2CSC_BIT_TX_REQ     1
`define I2CSC_BIT_RX_REQ     0
`define I2CSC_BIT_INT_FLAG   1
`define I2CSC_BIT_INT_EN     0
`define I2CSC_OWN_ADDR_RST   7'h39
`define I2CSC_INT_CLR_VAL    8'h80
`endif

// File: logic/i2csc_slave.v
// i2c slave controller with host register port
`timescale 1ns/1ps
`include "i2csc_defs.vh"
module i2csc_slave (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [31:0] addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  output reg         irq
);
  // -------------------------------------------------
  // states
  // -------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_AACK = 3'h2;
  localparam [2:0] ST_RXB  = 3'h3;
  localparam [2:0] ST_RACK = 3'h4;
  localparam [2:0] ST_TXB  = 3'h5;
  localparam [2:0] ST_TACK = 3'h6;
  localparam [2:0] ST_WAIT = 3'h7;

  // -------------------------------------------------
  // soft reset: same effect as rst_n
  // -------------------------------------------------
  reg  soft_rst;
  wire ctrl_wr = wr && (addr == `I2CSC_OFS_CTRL_STAT);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      soft_rst <= 1'b0;
    else
      soft_rst <= ctrl_wr && wdata[`I2CSC_BIT_SOFT_RST];
  end
  wire arst_n = rst_n & ~soft_rst;

  // -------------------------------------------------
  // pin synchronisers, three stages; sampled on clk, level taken after two equal samples
  // -------------------------------------------------
  reg [2:0] scl_s;
  reg [2:0] sda_s;
  reg       scl_f;
  reg       sda_f;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      if (scl_s[1] == scl_s[2])
        scl_f <= scl_s[2];
      if (sda_s[1] == sda_s[2])
        sda_f <= sda_s[2];
    end
  end
  wire new_scl = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
  wire new_sda = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
  wire scl_rise = new_scl & ~scl_f;
  wire scl_fall = ~new_scl & scl_f;
  wire start_c  = scl_f & new_scl & sda_f & ~new_sda;
  wire stop_c   = scl_f & new_scl & ~sda_f & new_sda;

  // -------------------------------------------------
  // registers and flags
  // -------------------------------------------------
  reg  [6:0] own_addr;
  reg  [6:0] own_upper;
  reg        dev_act;
  reg        dev_off_req;
  reg        bus_act;
  reg        rx_fin;
  reg        tx_fin;
  reg        rx_req;
  reg        tx_req;
  reg        int_flag;
  reg        int_en;
  reg  [7:0] tx_buf;
  reg  [7:0] rx_buf;
  reg  [7:0] shreg;
  reg  [3:0] bitcnt;
  reg  [2:0] state;
  reg        is_read;
  reg        got_nack;
  reg        was_write;

  wire data_wr = wr && (addr == `I2CSC_OFS_DATA);
  wire data_rd = rd && (addr == `I2CSC_OFS_DATA);
  wire int_wr  = wr && (addr == `I2CSC_OFS_INT_CTRL);
  wire int_clr = int_wr && (wdata[7:0] == `I2CSC_INT_CLR_VAL);
  reg  set_rx_fin;
  reg  set_tx_fin;
  reg  set_rx_req;
  reg  set_tx_req;
  reg  byte_done;

  // -------------------------------------------------
  // bus state machine
  // -------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_IDLE;
      shreg      <= 8'h00;
      bitcnt     <= 4'h0;
      is_read    <= 1'b0;
      got_nack   <= 1'b0;
      was_write  <= 1'b0;
      rx_buf     <= 8'h00;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      scl_out    <= 1'b0;
      scl_oe     <= 1'b0;
      bus_act    <= 1'b0;
      set_rx_fin <= 1'b0;
      set_tx_fin <= 1'b0;
      set_rx_req <= 1'b0;
      set_tx_req <= 1'b0;
      byte_done  <= 1'b0;
    end else begin
      set_rx_fin <= 1'b0;
      set_tx_fin <= 1'b0;
      set_rx_req <= 1'b0;
      set_tx_req <= 1'b0;
      byte_done  <= 1'b0;
      scl_out    <= 1'b0;
      scl_oe     <= (rx_req || tx_req) && !scl_f;
      if (stop_c || start_c) begin
        if (state != ST_IDLE && state != ST_ADDR) begin
          set_rx_fin <= was_write;
          set_tx_fin <= is_read;
        end
        sda_oe    <= 1'b0;
        was_write <= 1'b0;
        bitcnt    <= 4'h0;
        state     <= (start_c && dev_act) ? ST_ADDR : ST_IDLE;
        bus_act   <= start_c && dev_act;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe  <= 1'b0;
            bus_act <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], new_sda};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              if (shreg[7:1] == own_addr) begin
                is_read <= shreg[0];
                sda_out <= 1'b0;
                sda_oe  <= 1'b1;
                state   <= ST_AACK;
              end else begin
                state   <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              sda_oe <= 1'b0;
              if (is_read) begin
                set_tx_req <= 1'b1;
                state      <= ST_WAIT;
              end else begin
                was_write <= 1'b1;
                state     <= ST_RXB;
              end
            end
          end
          ST_RXB: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], new_sda};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              rx_buf     <= shreg;
              set_rx_req <= 1'b1;
              byte_done  <= 1'b1;
              sda_out    <= 1'b0;
              sda_oe     <= 1'b1;
              state      <= ST_RACK;
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bitcnt <= 4'h0;
              state  <= ST_RXB;
            end
          end
          ST_WAIT: begin
            if (!tx_req && !set_tx_req) begin
              shreg   <= {tx_buf[6:0], 1'b0};
              sda_out <= tx_buf[7];
              sda_oe  <= ~tx_buf[7];
              bitcnt  <= 4'h1;
              state   <= ST_TXB;
            end
          end
          ST_TXB: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe <= 1'b0;
                state  <= ST_TACK;
              end else begin
                sda_out <= shreg[7];
                sda_oe  <= ~shreg[7];
                shreg   <= {shreg[6:0], 1'b0};
                bitcnt  <= bitcnt + 4'h1;
              end
            end
          end
          ST_TACK: begin
            if (scl_rise)
              got_nack <= new_sda;
            else if (scl_fall) begin
              byte_done <= 1'b1;
              if (got_nack) begin
                set_tx_fin <= 1'b1;
                state      <= ST_IDLE;
              end else begin
                set_tx_req <= 1'b1;
                state      <= ST_WAIT;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // -------------------------------------------------
  // host registers and flags
  // -------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      own_addr    <= `I2CSC_OWN_ADDR_RST;
      own_upper   <= 7'h00;
      dev_act     <= 1'b0;
      dev_off_req <= 1'b0;
      rx_fin      <= 1'b0;
      tx_fin      <= 1'b0;
      rx_req      <= 1'b0;
      tx_req      <= 1'b0;
      int_flag    <= 1'b0;
      int_en      <= 1'b0;
      tx_buf      <= 8'h00;
      irq         <= 1'b0;
    end else begin
      if (wr && addr == `I2CSC_OFS_OWN_ADDR)
        own_addr <= wdata[6:0];
      if (wr && addr == `I2CSC_OFS_OWN_UPPER)
        own_upper <= wdata[6:0];
      if (ctrl_wr && wdata[`I2CSC_BIT_DEV_ACT]) begin
        dev_act     <= 1'b1;
        dev_off_req <= 1'b0;
      end else if (ctrl_wr) begin
        dev_off_req <= 1'b1;
      end else if (dev_off_req && state == ST_IDLE && !bus_act) begin
        dev_act     <= 1'b0;
        dev_off_req <= 1'b0;
      end
      if (set_rx_fin)
        rx_fin <= 1'b1;
      else if (ctrl_wr && wdata[`I2CSC_BIT_RX_FIN])
        rx_fin <= 1'b0;
      if (set_tx_fin)
        tx_fin <= 1'b1;
      else if (ctrl_wr && wdata[`I2CSC_BIT_TX_FIN])
        tx_fin <= 1'b0;
      if (set_rx_req)
        rx_req <= 1'b1;
      else if (data_rd)
        rx_req <= 1'b0;
      if (set_tx_req)
        tx_req <= 1'b1;
      else if (data_wr)
        tx_req <= 1'b0;
      if (data_wr)
        tx_buf <= wdata[7:0];
      if (int_wr)
        int_en <= wdata[`I2CSC_BIT_INT_EN];
      if (set_rx_fin || set_tx_fin || byte_done)
        int_flag <= 1'b1;
      else if (int_clr)
        int_flag <= 1'b0;
      irq <= int_en & (int_flag | rx_fin | tx_fin);
    end
  end

  // -------------------------------------------------
  // read port, data one cycle after strobe
  // -------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      rdata <= 32'h0000_0000;
    else if (!rd)
      rdata <= 32'h0000_0000;
    else if (addr == `I2CSC_OFS_OWN_ADDR)
      rdata <= {25'h0, own_addr};
    else if (addr == `I2CSC_OFS_CTRL_STAT)
      rdata <= {25'h0, dev_act, 1'b0, bus_act, rx_fin, tx_fin, tx_req, rx_req};
    else if (addr == `I2CSC_OFS_DATA)
      rdata <= {24'h0, rx_buf};
    else if (addr == `I2CSC_OFS_OWN_UPPER)
      rdata <= {25'h0, own_upper};
    else if (addr == `I2CSC_OFS_INT_CTRL)
      rdata <= {30'h0, int_flag, int_en};
    else
      rdata <= 32'h0000_0000;
  end
endmodule // i2csc_slave

// File: test/i2csc_checker.sv
// port checker for the i2c slave controller
`timescale 1ns/1ps
`include "i2csc_defs.vh"
module i2csc_checker (
  input wire        clk,
  input wire        rst_n,
  input wire [31:0] addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  input wire        scl_in,
  input wire        scl_out,
  input wire        scl_oe,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_oe,
  input wire        irq
);
  wire st = addr == `I2CSC_OFS_CTRL_STAT;
  wire dt = addr == `I2CSC_OFS_DATA;
  wire cw = wr && st && !wdata[7];
  wire sr = rd && st;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------
  // checks
  // ------
  idle_rdata_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("rdata without read");
  dir_excl_a: assert property (sr |=> !(rdata[0] && rdata[1]))
    else $error("both requests set");
  soft_rst_a: assert property (wr && st && wdata[7] |-> ##[1:2] !(irq | sda_oe | scl_oe))
    else $error("soft reset ignored");
  da_set_a: assert property (cw && wdata[6] ##[1:2] sr |=> rdata[6])
    else $error("device active not set");
  rxfin_clr_a: assert property (cw && wdata[3] ##[1:2] sr |=> !rdata[3])
    else $error("receive finished kept");
  txfin_clr_a: assert property (cw && wdata[2] ##[1:2] sr |=> !rdata[2])
    else $error("send finished kept");
  receive_request_clr_a: assert property (rd && dt ##[1:2] sr |=> !rdata[0])
    else $error("receive request kept");
  transmit_request_clr_a: assert property (wr && dt ##[1:2] sr |=> !rdata[1])
    else $error("transmit request kept");
  scl_low_a: assert property (scl_oe |-> !scl_out)
    else $error("scl driven high");
  sda_low_a: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  cover property (rd && dt);
  cover property (wr && dt);
  cover property (wr && st && wdata[7]);
endmodule // i2csc_checker
bind i2csc_slave i2csc_checker i_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

// File: test/i2csc_master_model.sv
// i2c bus master model for the far side of the link
`timescale 1ns/1ps
module i2csc_master_model (
  input wire scl,
  input wire sda,
  output reg scl_lo,
  output reg sda_lo
);
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  // release scl and wait up to 50000 ns for a stretch to end
  task automatic rise;
    int n;
    scl_lo = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 50000) begin
      #1;
      n++;
    end
    #62.5;
  endtask
  task automatic bit_io(input b, output r);
    sda_lo = ~b;
    #42.5;
    rise;
    r = sda;
    scl_lo = 1'b1;
    #20;
  endtask
  task automatic xfer(input [7:0] d, input ai, output [7:0] q, output ao);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, ao);
  endtask
  task automatic start;
    sda_lo = 1'b0;
    #20;
    rise;
    sda_lo = 1'b1;
    #62.5;
    scl_lo = 1'b1;
    #20;
  endtask
  task automatic stop;
    sda_lo = 1'b1;
    #20;
    rise;
    sda_lo = 1'b0;
    #62.5;
  endtask
endmodule // i2csc_master_model

// File: test/tb_top.sv
// self-checking bench for the i2c slave controller
`timescale 1ns/1ps
`include "i2csc_defs.vh"
module tb_top;
  localparam [31:0] OA = `I2CSC_OFS_OWN_ADDR;
  localparam [31:0] ST = `I2CSC_OFS_CTRL_STAT;
  localparam [31:0] DT = `I2CSC_OFS_DATA;
  localparam [31:0] IR = `I2CSC_OFS_INT_CTRL;
  reg         clk, rst_n, wr, rd, ak;
  reg  [31:0] addr, wdata, r;
  reg  [7:0]  q;
  wire [31:0] rdata;
  wire        scl_out, scl_oe, sda_out, sda_oe, irq, m_scl, m_sda;
  int         error_cnt = 0;
  int         n_tests = 0;
  wire scl = ~(m_scl | (scl_oe & ~scl_out));
  wire sda = ~(m_sda | (sda_oe & ~sda_out));
  i2csc_slave i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  i2csc_master_model i_mst (.scl(scl), .sda(sda), .scl_lo(m_scl), .sda_lo(m_sda));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ------
  // tasks
  // ------
  task wr_reg(input [31:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [31:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask
  task chk(input [31:0] s, e, input string n);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task rchk(input [31:0] a, m, e, input string n);
    rd_reg(a);
    chk(r & m, e, n);
  endtask
  task poll(input int b, input v);
    for (int n = 0; n < 2000; n++) begin
      rd_reg(ST);
      if (r[b] === v)
        break;
    end
    chk(r[b], v, "status poll");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
  // ------
  // tests
  // ------
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 32'h0;
    wdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rchk(OA, 32'hff, 32'h39, "own addr reset");
    rchk(ST, 32'hff, 32'h0, "status reset");
    rchk(32'h5000_3800, 32'hffffffff, 32'h0, "unmapped");
    wr_reg(OA, 32'h2a);
    rchk(OA, 32'hff, 32'h2a, "own addr");
    wr_reg(IR, 32'h1);
    wr_reg(ST, 32'h40);
    rchk(ST, 32'hff, 32'h40, "device active");
    i_mst.start;
    i_mst.xfer(8'h72, 1'b1, q, ak);
    i_mst.stop;
    chk(ak, 1'b1, "foreign address");
    $display("registers and addressing done");
    fork
      begin
        i_mst.start;
        i_mst.xfer(8'h54, 1'b1, q, ak);
        chk(ak, 1'b0, "address ack");
        i_mst.xfer(8'ha6, 1'b1, q, ak);
        i_mst.xfer(8'h3d, 1'b1, q, ak);
        chk(ak, 1'b0, "data ack");
        i_mst.stop;
      end
      begin
        poll(0, 1'b1);
        rchk(DT, 32'hffffffff, 32'ha6, "rx byte 0");
        rchk(ST, 32'h51, 32'h50, "busy and active");
        wr_reg(ST, 32'h0);
        rchk(ST, 32'h40, 32'h40, "active held");
        poll(0, 1'b1);
        rchk(DT, 32'hff, 32'h3d, "rx byte 1");
      end
    join
    poll(6, 1'b0);
    poll(3, 1'b1);
    chk(irq, 1'b1, "irq on finish");
    wr_reg(ST, 32'h48);
    rchk(ST, 32'hff, 32'h40, "rx finish clear");
    $display("master write done");
    fork
      begin
        i_mst.start;
        i_mst.xfer(8'h55, 1'b1, q, ak);
        i_mst.xfer(8'hff, 1'b0, q, ak);
        chk(q, 8'hb1, "tx byte 0");
        i_mst.xfer(8'hff, 1'b1, q, ak);
        chk(q, 8'h4e, "tx byte 1");
        i_mst.stop;
      end
      begin
        poll(1, 1'b1);
        wr_reg(DT, 32'hb1);
        rchk(ST, 32'h2, 32'h0, "transmit_request cleared");
        poll(1, 1'b1);
        wr_reg(DT, 32'h4e);
      end
    join
    poll(2, 1'b1);
    wr_reg(ST, 32'h44);
    rchk(ST, 32'hff, 32'h40, "tx finish clear");
    chk(irq, 1'b1, "flag sticky");
    wr_reg(IR, 32'h80);
    rchk(IR, 32'h2, 32'h0, "flag cleared");
    chk(irq, 1'b0, "irq cleared");
    $display("master read done");
    wr_reg(ST, 32'h80);
    repeat (3) @(posedge clk);
    rchk(OA, 32'hff, 32'h39, "addr after soft reset");
    rchk(ST, 32'hff, 32'h0, "status after soft reset");
    $display("soft reset done");
    report_and_stop;
  end
endmodule // tb_top
